// ### hdl/sdram_init_map.svh
/*
  constants for the sdram init and address map block: field positions,
  command mode codes, pin command encodings, reset values and the power-up wait.
  assumes one 10 MHz system clock; included by bare name.
*/
// Summary of operation
// - bit0 byte select, then column, row, bank
// - upper bank bit to line1, lower to line0
// - mode 1 plus sdram write issues nop
// - mode 2 plus write issues precharge all
// - mode 4 each write one auto refresh, none during the wait or in the cycle after one
`ifndef SDRAM_INIT_MAP_SVH
`define SDRAM_INIT_MAP_SVH
`define MODE_NORMAL      3'h0
`define MODE_NOP         3'h1
`define MODE_PRECHARGE   3'h2
`define MODE_REFRESH     3'h4
`define CMD_INHIBIT      4'hF
`define CMD_NOP          4'h7
`define CMD_PRECHARGE    4'h2
`define CMD_REFRESH      4'h1
`define COL_LSB          1
`define ROW_BITS_MIN     12
`define COL_BITS_MIN     8
`define PRECHARGE_A10    10
`define REFRESH_COUNT    4'h8
`define POWERUP_WAIT_US  200
`define CLK_MHZ          10
`define POWERUP_CYCLES   (`POWERUP_WAIT_US * `CLK_MHZ)
`endif

// ### hdl/sdram_init_pkg.sv
/*
  types for the sdram init and address map block.
  assumes sdram_init_map.svh for the numbers.
*/
package sdram_init_pkg;
    typedef struct packed {
        logic [3:0]  cmd;
        logic [1:0]  bank;
        logic [12:0] addr;
    } sdram_cmd_t;

    typedef struct packed {
        logic [1:0] col_sel;
        logic       row_sel;
    } geom_t;

    typedef enum logic [1:0] {
        ST_WAIT,
        ST_IDLE,
        ST_ISSUE
    } init_state_t;
endpackage

// ### hdl/sdram_init_addr_map.sv
/*
  sdram init command issue and system address split into bank, row, column.
  assumes software keeps the configuration order and that bus inputs are
  synchronous to sys_clk; one access strobe per cycle at most.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdram_init_map.svh"
module sdram_init_addr_map
    import sdram_init_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire geom_t       geom,
    input  wire logic [2:0]  mode_field,
    input  wire logic        sdram_wr,
    input  wire logic [27:0] sys_addr,
    output var  sdram_cmd_t  sdram_out,
    output var  logic        halfword_byte_select,
    output var  logic        bank_addr_line_0,
    output var  logic        bank_addr_line_1,
    output var  logic [10:0] column_q,
    output var  logic [12:0] row_q,
    output var  logic        powerup_done,
    output var  logic        cmd_pending,
    output var  logic [3:0]  refresh_count
);
    localparam int WAIT_CYC = `POWERUP_CYCLES;

    init_state_t state_q, state_d;
    logic [11:0] wait_q;
    logic [2:0]  mode_q;
    logic        pend_q;
    logic [3:0]  ref_q;

    // column width 8..11, row 12..13; split is a function, called once to build fields
    function automatic logic [25:0] split(input logic [27:0] a, input geom_t g);
        logic [4:0]  cb;
        logic [27:0] r;
        cb = 5'(`COL_BITS_MIN) + 5'(g.col_sel);
        r = a >> (`COL_LSB + cb);
        split[10:0] = 11'(a >> `COL_LSB) & ((11'h1 << cb) - 11'h1);
        split[23:11] = g.row_sel ? r[12:0] : {1'b0, r[11:0]};
        split[25:24] = g.row_sel ? 2'(r >> 13) : 2'(r >> 12);
    endfunction

    // special-mode decode is shared by the arming logic, the status output and the checks
    function automatic logic is_special(input logic [2:0] m);
        is_special = (m == `MODE_NOP) || (m == `MODE_PRECHARGE) || (m == `MODE_REFRESH);
    endfunction

    wire [25:0] fields     = split(sys_addr, geom);
    wire        mode_write = (mode_field != mode_q);
    wire        special    = is_special(mode_q);
    wire        fire       = (state_q == ST_IDLE) && sdram_wr && pend_q;
    wire [3:0]  fire_cmd   = (mode_q == `MODE_NOP) ? `CMD_NOP :
                             (mode_q == `MODE_PRECHARGE) ? `CMD_PRECHARGE : `CMD_REFRESH;
    wire        wait_end   = (wait_q == 12'(WAIT_CYC - 1));
    wire        refresh_mode = (mode_q == `MODE_REFRESH);
    wire        prech_mode   = (mode_q == `MODE_PRECHARGE);
    // a10 high on precharge selects all banks, so the bank lines do not matter then
    wire [12:0] prech_addr   = 13'h0001 << `PRECHARGE_A10;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_WAIT:  if (wait_end) state_d = ST_IDLE;
            ST_IDLE:  if (fire) state_d = ST_ISSUE;
            ST_ISSUE: state_d = ST_IDLE;
            // code 3 is unreachable; falling back to the wait keeps the pins quiet
            default:  state_d = ST_WAIT;
        endcase
    end

    // the wait counter freezes once the wait is over, so it never wraps
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_WAIT;
            wait_q  <= 12'h000;
        end else begin
            state_q <= state_d;
            if (state_q == ST_WAIT) wait_q <= wait_q + 12'h001;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= `MODE_NORMAL;
        end else begin
            mode_q <= mode_field;
        end
    end

    // a new special mode arms its command; a write in the same cycle still uses the old one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_q <= 1'b0;
        end else if (mode_write) begin
            pend_q <= is_special(mode_field);
        end else if (fire && !refresh_mode) begin
            pend_q <= 1'b0;
        end
    end

    // refresh stays armed, so one mode write covers all eight cycles
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_q <= 4'h0;
        end else if (mode_write) begin
            ref_q <= 4'h0;
        end else if (fire && refresh_mode) begin
            ref_q <= ref_q + 4'h1;
        end
    end

    // command pins stay inhibited until the power-up wait has run out; the address outputs below still follow writes during it
    // the address split is latched on every write, special or not
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            halfword_byte_select <= 1'b0;
            bank_addr_line_0     <= 1'b0;
            bank_addr_line_1     <= 1'b0;
            column_q             <= 11'h000;
            row_q                <= 13'h0000;
        end else if (sdram_wr) begin
            halfword_byte_select <= sys_addr[0];
            bank_addr_line_1     <= fields[25];
            bank_addr_line_0     <= fields[24];
            column_q             <= fields[10:0];
            row_q                <= fields[23:11];
        end
    end

    // command bus is a one-cycle pulse; the issue state blocks a second one right behind it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sdram_out <= '{cmd: `CMD_INHIBIT, bank: 2'h0, addr: 13'h0000};
        end else begin
            sdram_out.cmd  <= fire ? fire_cmd : `CMD_INHIBIT;
            sdram_out.bank <= fire ? fields[25:24] : 2'h0;
            sdram_out.addr <= (fire && prech_mode) ? prech_addr : 13'h0000;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            powerup_done  <= 1'b0;
            cmd_pending   <= 1'b0;
            refresh_count <= 4'h0;
        end else begin
            powerup_done  <= (state_d != ST_WAIT);
            cmd_pending   <= pend_q && special;
            refresh_count <= ref_q;
        end
    end

    a_nop_issue: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fire && mode_q == `MODE_NOP |=> sdram_out.cmd == `CMD_NOP)
        else $error("nop not issued");
    a_prech_issue: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fire && mode_q == `MODE_PRECHARGE |=> sdram_out.cmd == `CMD_PRECHARGE && sdram_out.addr[10])
        else $error("precharge all not issued");
    a_refresh_count: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fire && mode_q == `MODE_REFRESH && !mode_write |=> ref_q == $past(ref_q) + 4'h1)
        else $error("refresh not counted");
    a_no_early_cmd: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !powerup_done |-> sdram_out.cmd == `CMD_INHIBIT)
        else $error("command before power-up wait");
    a_hold_pending: assert property (@(posedge sys_clk) disable iff (!arst_n)
        !sdram_wr && !mode_write |=> sdram_out.cmd == `CMD_INHIBIT)
        else $error("command without sdram access");
    a_bank_lines: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sdram_wr |=> {bank_addr_line_1, bank_addr_line_0} == $past(fields[25:24]))
        else $error("bank lines swapped");
    a_byte_sel: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sdram_wr |=> halfword_byte_select == $past(sys_addr[0]))
        else $error("byte select wrong");
    a_one_shot: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fire && mode_q != `MODE_REFRESH && !mode_write |=> !pend_q)
        else $error("command fired twice");
    a_wait_status: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_q == ST_WAIT |-> !powerup_done)
        else $error("power-up reported early");
    a_wait_quiet: assert property (@(posedge sys_clk) disable iff (!arst_n)
        state_q == ST_WAIT |=> sdram_out.cmd == `CMD_INHIBIT)
        else $error("pins toggled during wait");
    a_cmd_pulse: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sdram_out.cmd != `CMD_INHIBIT |=> sdram_out.cmd == `CMD_INHIBIT)
        else $error("command held too long");
    a_refresh_issue: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fire && refresh_mode |=> sdram_out.cmd == `CMD_REFRESH)
        else $error("refresh not issued");
    a_ref_clear: assert property (@(posedge sys_clk) disable iff (!arst_n)
        mode_write |=> ref_q == 4'h0)
        else $error("refresh count not cleared");
    a_fire_bank: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fire |=> sdram_out.bank == $past(fields[25:24]))
        else $error("command bank wrong");
    a_col_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sdram_wr |=> column_q[7:0] == $past(sys_addr[8:1]))
        else $error("column field wrong");
    a_row_low: assert property (@(posedge sys_clk) disable iff (!arst_n)
        sdram_wr |=> row_q[11:0] == 12'($past(sys_addr) >> (9 + $past(geom.col_sel))))
        else $error("row field wrong");
    a_plain_mode: assert property (@(posedge sys_clk) disable iff (!arst_n)
        mode_write && !is_special(mode_field) |=> !pend_q)
        else $error("normal mode armed a command");
    a_prech_only: assert property (@(posedge sys_clk) disable iff (!arst_n)
        fire && !prech_mode |=> !sdram_out.addr[10])
        else $error("all-bank bit outside precharge");

    c_nop: cover property (@(posedge sys_clk) sdram_out.cmd == `CMD_NOP);
    c_early_wr: cover property (@(posedge sys_clk) state_q == ST_WAIT && sdram_wr && pend_q);
    c_refresh: cover property (@(posedge sys_clk) sdram_out.cmd == `CMD_REFRESH);
    c_prech: cover property (@(posedge sys_clk) sdram_out.cmd == `CMD_PRECHARGE);
    c_eight_ref: cover property (@(posedge sys_clk) ref_q == `REFRESH_COUNT);
endmodule
`default_nettype wire

// ### sim/sdram_model.sv
/* far-side sdram model: counts commands seen on the pins.
   assumes the init block's registered command bus in the sys_clk domain. */
`timescale 1ns/100ps
`default_nettype none
`include "sdram_init_map.svh"
module sdram_model
    import sdram_init_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       arst_n,
    input wire sdram_cmd_t pins
);
    int          up;
    int          n_early = 0;
    int          n_nop = 0;
    int          n_pre = 0;
    int          n_ref = 0;
    logic [12:0] pre_addr = '0;
    logic [1:0]  pre_bank = '0;
    // counting only; a real part would also need the mode load after refresh
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            up <= 0;
        end else begin
            up <= up + 1;
            if (pins.cmd !== `CMD_INHIBIT && up < `POWERUP_CYCLES) n_early <= n_early + 1;
            if (pins.cmd === `CMD_NOP) n_nop <= n_nop + 1;
            if (pins.cmd === `CMD_PRECHARGE) n_pre <= n_pre + 1;
            if (pins.cmd === `CMD_PRECHARGE) pre_addr <= pins.addr;
            if (pins.cmd === `CMD_PRECHARGE) pre_bank <= pins.bank;
            if (pins.cmd === `CMD_REFRESH) n_ref <= n_ref + 1;
        end
    end
endmodule
`default_nettype wire

// ### sim/sdram_init_addr_map_tb.sv
/* testbench for the sdram init and address map block.
   assumes the sdram model beside it and a 10 MHz clock. */
`timescale 1ns/100ps
`default_nettype none
module sdram_init_addr_map_tb;
    import sdram_init_pkg::*;
    logic        sys_clk = 0;
    logic        arst_n = 0;
    logic        sdram_wr = 0;
    geom_t       geom = '0;
    logic [2:0]  mode_field = 3'h0;
    logic [27:0] sys_addr = '0;
    sdram_cmd_t  sdram_out;
    logic        hbs, ba0, ba1, pdone, pend;
    logic [10:0] col;
    logic [12:0] row;
    logic [3:0]  rcnt;
    int          miscompares = 0;
    int          total_checks = 0;
    sdram_init_addr_map sdram_init_addr_map_i (.sys_clk(sys_clk), .arst_n(arst_n), .geom(geom),
        .mode_field(mode_field), .sdram_wr(sdram_wr), .sys_addr(sys_addr), .sdram_out(sdram_out),
        .halfword_byte_select(hbs), .bank_addr_line_0(ba0), .bank_addr_line_1(ba1), .column_q(col),
        .row_q(row), .powerup_done(pdone), .cmd_pending(pend), .refresh_count(rcnt));
    sdram_model sdram_model_i (.sys_clk(sys_clk), .arst_n(arst_n), .pins(sdram_out));
    initial forever #50 sys_clk = ~sys_clk;
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // writes stay five cycles apart, well past the refused slot after a fire
    task wr(input logic [27:0] a);
        @(posedge sys_clk);
        sdram_wr <= 1'b1;
        sys_addr <= a;
        @(posedge sys_clk);
        sdram_wr <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task mode(input logic [2:0] m);
        @(posedge sys_clk);
        mode_field <= m;
        repeat (2) @(posedge sys_clk);
    endtask
    task t_early;
        chk("cmd", 32'(sdram_out.cmd), 32'hF);
        mode(3'h1);
        wr(28'h0000010);
        chk("early", sdram_model_i.n_early + sdram_model_i.n_nop, 32'h0);
        chk("pend", 32'(pend), 32'h1);
        for (int i = 0; i < 2100 && pdone !== 1'b1; i++) @(posedge sys_clk);
        chk("pdone", 32'(pdone), 32'h1);
    endtask
    task t_cmds;
        wr(28'h0000123);
        chk("nop", sdram_model_i.n_nop, 32'h1);
        wr(28'h0000124);
        chk("nop2", sdram_model_i.n_nop, 32'h1);
        chk("pend0", 32'(pend), 32'h0);
        mode(3'h2);
        wr(28'h0400200);
        chk("pre", sdram_model_i.n_pre, 32'h1);
        chk("pre_bank", 32'(sdram_model_i.pre_bank), 32'h2);
        chk("pre_addr", 32'(sdram_model_i.pre_addr), 32'h400);
        mode(3'h4);
        repeat (8) wr(28'h0000300);
        chk("ref", sdram_model_i.n_ref, 32'h8);
        chk("rcnt", 32'(rcnt), 32'h8);
    endtask
    task t_map;
        logic [27:0] a;
        a = 28'hABCDEF5;
        mode(3'h0);
        for (int cs = 0; cs < 4; cs++) begin
            for (int rs = 0; rs < 2; rs++) begin
                geom <= '{col_sel: 2'(cs), row_sel: 1'(rs)};
                wr(a);
                chk("m0", 32'(hbs), 32'(a[0]));
                chk("col", 32'(col), (a >> 1) & ((1 << (8 + cs)) - 1));
                chk("row", 32'(row), (a >> (9 + cs)) & ((1 << (12 + rs)) - 1));
                chk("bank", {ba1, ba0}, (a >> (21 + cs + rs)) & 3);
            end
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        t_early();
        t_cmds();
        t_map();
        wrap_up();
    end
    initial begin
        #1000000;
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
